//--- sbbi_bank_timer.sv
`default_nettype none

// ----------------------------------------------------------------------
// shared constants and carriers
// ----------------------------------------------------------------------
package sbbi_pkg;
  localparam int BANKS         = 4;
  localparam int BANK_W        = 2;
  localparam int COL_W         = 8;
  localparam int DQ_W          = 16;
  localparam int MASK_W        = 2;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CAS_LATENCY   = 3;
  localparam int BURST_LEN     = 4;
  // write recovery and precharge period, in ns
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int PRECHARGE_TIME_NS      = 20;
  // least times round up to whole cycles
  localparam int WR_CYCLES =
    (WRITE_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYCLES =
    (PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
    logic              auto_pre;
  } sbbi_cmd_t;

  typedef struct packed {
    logic              en;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
    logic [DQ_W-1:0]   data;
    logic [MASK_W-1:0] mask;
  } sbbi_wr_t;
endpackage

// ----------------------------------------------------------------------
// per-bank auto precharge timer
// ----------------------------------------------------------------------
module sbbi_bank_timer #(
  parameter int WR_CYC = sbbi_pkg::WR_CYCLES,
  parameter int RP_CYC = sbbi_pkg::RP_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic wait_wr_i,
  output logic      pre_start_o,
  output logic      busy_o
);
  typedef enum logic [1:0] {SBBI_IDLE, SBBI_RECOVER, SBBI_PRECH} sbbi_tst_t;

  sbbi_tst_t                  state;
  logic [sbbi_pkg::CNT_W-1:0] cnt;

  initial begin
    if (WR_CYC < 1 || RP_CYC < 1 || WR_CYC > 255 || RP_CYC > 255)
      $error("sbbi_bank_timer: cycle counts out of range");
  end

  assign busy_o = (state != SBBI_IDLE);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= SBBI_IDLE;
      cnt         <= 8'h00;
      pre_start_o <= 1'b0;
    end else begin
      pre_start_o <= 1'b0;
      if (start_i && state != SBBI_PRECH) begin
        if (wait_wr_i) begin
          // recovery counted from the edge that starts it
          state <= SBBI_RECOVER;
          cnt   <= sbbi_pkg::CNT_W'(WR_CYC);
        end else begin
          state       <= SBBI_PRECH;
          cnt         <= sbbi_pkg::CNT_W'(RP_CYC);
          pre_start_o <= 1'b1;
        end
      end else begin
        unique case (state)
          SBBI_IDLE: ;
          SBBI_RECOVER: begin
            // precharge opens exactly wr cycles after the starting edge
            if (cnt == 8'h01) begin
              state       <= SBBI_PRECH;
              cnt         <= sbbi_pkg::CNT_W'(RP_CYC);
              pre_start_o <= 1'b1;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          SBBI_PRECH: begin
            if (cnt == 8'h01)
              state <= SBBI_IDLE;
            cnt <= cnt - 8'h01;
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

//--- sbbi_burst_ctrl.sv
`default_nettype none

// Operation
// - an auto precharge burst cut short by another bank's burst starts its bank's precharge on its own.
// - a running burst carries on as started while another bank gets an activate; a precharge to another bank skips that clock's beat.
// - a read to another bank takes over the output one CAS latency after it is taken.
// - a write to another bank ends a plain read on the edge the write is taken.
// - a read ends a write when taken; the last stored word is the one of the clock before.
// - a write ends a plain write when taken and its own data is stored from that edge.
// - a read cutting an auto precharge read starts that bank's precharge on its own edge.
// - a write cutting an auto precharge read stops it and starts precharge on that edge.
// - a read cutting an auto precharge write starts precharge after write recovery from its edge.
// - a write cutting an auto precharge write keeps the prior word and precharges after recovery.

module sbbi_burst_ctrl #(
  parameter int CAS_LAT = sbbi_pkg::CAS_LATENCY,
  parameter int BL      = sbbi_pkg::BURST_LEN,
  parameter int WR_CYC  = sbbi_pkg::WR_CYCLES,
  parameter int RP_CYC  = sbbi_pkg::RP_CYCLES
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire sbbi_pkg::sbbi_cmd_t           cmd_i,
  input  wire logic [sbbi_pkg::MASK_W-1:0]   dqm_i,
  input  wire logic [sbbi_pkg::DQ_W-1:0]     dq_i,
  output logic [sbbi_pkg::DQ_W-1:0]          dq_o,
  output logic                               dq_oe_o,
  output logic                               arr_rd_en_o,
  output logic [sbbi_pkg::BANK_W-1:0]        arr_rd_bank_o,
  output logic [sbbi_pkg::COL_W-1:0]         arr_rd_col_o,
  input  wire logic [sbbi_pkg::DQ_W-1:0]     arr_rd_data_i,
  output sbbi_pkg::sbbi_wr_t                 arr_wr_o,
  output logic [sbbi_pkg::BANKS-1:0]         pre_start_o,
  output logic [sbbi_pkg::BANKS-1:0]         bank_busy_o,
  output logic                               burst_active_o
);
  localparam int BANKS = sbbi_pkg::BANKS;
  localparam int COL_W = sbbi_pkg::COL_W;
  localparam int DQ_W  = sbbi_pkg::DQ_W;
  localparam int PIPE  = CAS_LAT - 1;

  initial begin
    if (CAS_LAT < 2 || CAS_LAT > 3)
      $error("sbbi_burst_ctrl: CAS latency must be 2 or 3");
    if (BL != 1 && BL != 2 && BL != 4 && BL != 8)
      $error("sbbi_burst_ctrl: burst length must be 1, 2, 4 or 8");
  end

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // wrap inside the burst-length aligned block, sequential order
  function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c);
    logic [COL_W-1:0] msk;
    logic [COL_W-1:0] inc;
    msk = COL_W'(BL - 1);
    inc = c + 8'h01;
    return (c & ~msk) | (inc & msk);
  endfunction

  // --------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------
  logic sel;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic is_bst;
  logic new_burst;

  assign sel    = ~cmd_i.cs_n;
  assign is_rd  = sel & cmd_i.ras_n & ~cmd_i.cas_n & cmd_i.we_n;
  assign is_wr  = sel & cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
  assign is_pre = sel & ~cmd_i.ras_n & cmd_i.cas_n & ~cmd_i.we_n;
  // terminate hits the newest burst only; the controller aims it right
  assign is_bst = sel & cmd_i.ras_n & cmd_i.cas_n & ~cmd_i.we_n;
  assign new_burst = is_rd | is_wr;

  // --------------------------------------------------------------------
  // running burst
  // --------------------------------------------------------------------
  logic                        burst_wr;
  logic                        burst_ap;
  logic [sbbi_pkg::BANK_W-1:0] burst_bank;
  logic [COL_W-1:0]            burst_col;
  logic [3:0]                  burst_left;
  logic                        burst_on;
  logic                        last_beat;
  logic                        interrupt;

  assign burst_on       = (burst_left != 4'h0);
  assign burst_active_o = burst_on;
  assign last_beat      = burst_on && burst_left == 4'h1 && !new_burst
                          && !is_bst;
  assign interrupt      = new_burst && burst_on && burst_ap
                          && burst_bank != cmd_i.bank;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_wr   <= 1'b0;
      burst_ap   <= 1'b0;
      burst_bank <= 2'h0;
      burst_col  <= 8'h00;
      burst_left <= 4'h0;
    end else if (new_burst) begin
      // a new write owns the data bus from this edge, a new read only CL later
      burst_wr   <= is_wr;
      burst_ap   <= cmd_i.auto_pre;
      burst_bank <= cmd_i.bank;
      burst_col  <= next_col(cmd_i.col);
      burst_left <= 4'(BL - 1);
    end else if (is_bst ||
                 (is_pre && (cmd_i.auto_pre || cmd_i.bank == burst_bank))) begin
      burst_left <= 4'h0;
    end else if (burst_on) begin
      // other-bank activates and idles leave the burst untouched
      burst_col  <= next_col(burst_col);
      burst_left <= burst_left - 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // array write path
  // --------------------------------------------------------------------
  // a read taken on this edge stores nothing: the last word written
  // was the one sampled on the edge before
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arr_wr_o <= '0;
    end else begin
      arr_wr_o.en   <= 1'b0;
      arr_wr_o.data <= dq_i;
      arr_wr_o.mask <= dqm_i;
      if (is_wr) begin
        arr_wr_o.en   <= 1'b1;
        arr_wr_o.bank <= cmd_i.bank;
        arr_wr_o.col  <= cmd_i.col;
      end else if (burst_on && burst_wr && !is_rd && !is_bst
                   && !is_pre) begin
        arr_wr_o.en   <= 1'b1;
        arr_wr_o.bank <= burst_bank;
        arr_wr_o.col  <= burst_col;
      end
    end
  end

  // --------------------------------------------------------------------
  // array read request and output pipeline
  // --------------------------------------------------------------------
  logic            rd_valid [PIPE];
  logic [DQ_W-1:0] rd_data  [PIPE];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arr_rd_en_o   <= 1'b0;
      arr_rd_bank_o <= 2'h0;
      arr_rd_col_o  <= 8'h00;
    end else if (is_rd) begin
      arr_rd_en_o   <= 1'b1;
      arr_rd_bank_o <= cmd_i.bank;
      arr_rd_col_o  <= cmd_i.col;
    end else if (burst_on && !burst_wr && !is_wr && !is_bst
                 && !is_pre) begin
      arr_rd_en_o   <= 1'b1;
      arr_rd_bank_o <= burst_bank;
      arr_rd_col_o  <= burst_col;
    end else begin
      arr_rd_en_o   <= 1'b0;
    end
  end

  // older read words still drain; a new read lands CL after its edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < PIPE; i++) begin
        rd_valid[i] <= 1'b0;
        rd_data[i]  <= 16'h0000;
      end
    end else begin
      rd_valid[0] <= arr_rd_en_o;
      rd_data[0]  <= arr_rd_data_i;
      for (int i = 1; i < PIPE; i++) begin
        rd_valid[i] <= rd_valid[i-1];
        rd_data[i]  <= rd_data[i-1];
      end
      if (is_wr) begin
        // the controller masks the tail so nothing collides here
        for (int i = 0; i < PIPE; i++)
          rd_valid[i] <= 1'b0;
      end
    end
  end

  // the pipe is cleared on a write edge, so the bus turns around at once
  assign dq_o    = rd_data[PIPE-1];
  assign dq_oe_o = rd_valid[PIPE-1] & ~is_wr;

  // --------------------------------------------------------------------
  // concurrent auto precharge
  // --------------------------------------------------------------------
  logic [BANKS-1:0] tm_start;
  logic [BANKS-1:0] tm_wait;

  always_comb begin
    tm_start = '0;
    tm_wait  = '0;
    if (interrupt) begin
      // read banks precharge now, write banks after recovery
      tm_start[burst_bank] = 1'b1;
      tm_wait[burst_bank]  = burst_wr;
    end
    if (last_beat && burst_ap) begin
      tm_start[burst_bank] = 1'b1;
      tm_wait[burst_bank]  = burst_wr;
    end
    if (new_burst && cmd_i.auto_pre && BL == 1) begin
      tm_start[cmd_i.bank] = 1'b1;
      tm_wait[cmd_i.bank]  = is_wr;
    end
    if (is_pre) begin
      for (int b = 0; b < BANKS; b++) begin
        if (cmd_i.auto_pre || cmd_i.bank == b[1:0]) begin
          tm_start[b] = 1'b1;
          tm_wait[b]  = 1'b0;
        end
      end
    end
  end

  // the controller must not reactivate a bank while its timer is busy
  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    sbbi_bank_timer #(
      .WR_CYC (WR_CYC),
      .RP_CYC (RP_CYC)
    ) u_timer (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .start_i     (tm_start[g]),
      .wait_wr_i   (tm_wait[g]),
      .pre_start_o (pre_start_o[g]),
      .busy_o      (bank_busy_o[g])
    );
  end
endmodule

`default_nettype wire

//--- sbbi_burst_ctrl_asserts.sv
`default_nettype none

// ------------------------------------
// burst interrupt checker
// ------------------------------------
module sbbi_chk #(
  parameter int BL     = 4,
  parameter int WR_CYC = 2
) (
  input wire logic                sys_clk_i,
  input wire logic                rst_i,
  input wire sbbi_pkg::sbbi_cmd_t cmd_i,
  input wire logic [1:0]          dqm_i,
  input wire logic [15:0]         dq_i,
  input wire logic                dq_oe_o,
  input wire logic                arr_rd_en_o,
  input wire logic [1:0]          arr_rd_bank_o,
  input wire sbbi_pkg::sbbi_wr_t  arr_wr_o,
  input wire logic [3:0]          pre_start_o
);
  localparam int WR_DLY = WR_CYC + 1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire rd = !cmd_i.cs_n && cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
  wire wr = !cmd_i.cs_n && cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
  wire quiet = cmd_i.cs_n || (cmd_i.cas_n && cmd_i.we_n);
  logic [2:0] left;
  logic [1:0] cb;
  logic       cap;
  logic       cwr;
  // only a live auto precharge burst cut by another bank counts
  wire        cut = (rd || wr) && left != 3'h0 && cap && cmd_i.bank != cb;
  wire [3:0]  oh = 4'h1 << cb;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      left <= 3'h0;
      cap  <= 1'b0;
    end else if (rd || wr) begin
      left <= 3'(BL - 1);
      cap  <= cmd_i.auto_pre;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rd || wr) begin
      cb  <= cmd_i.bank;
      cwr <= wr;
    end
  end
  sequence rd_quiet;
    rd ##1 quiet [*6];
  endsequence
  sequence rd_clear;
    rd ##1 !wr [*2];
  endsequence
  a_burst_runs: assert property (
    rd_quiet |-> dq_oe_o && $past(dq_oe_o, 3) ##1 !dq_oe_o)
    else $error("read burst length wrong");
  a_rd_latency: assert property (rd_clear |-> ##1 (dq_oe_o || wr))
    else $error("read data late");
  a_rd_request: assert property (
    rd |=> arr_rd_en_o && arr_rd_bank_o == $past(cmd_i.bank))
    else $error("read not sent to array");
  a_wr_gate: assert property (wr |-> !dq_oe_o [*3])
    else $error("output on during write");
  a_wr_beat: assert property (
    wr |=> arr_wr_o == {1'b1, $past(cmd_i.bank), $past(cmd_i.col),
                        $past(dq_i), $past(dqm_i)})
    else $error("first write beat wrong");
  a_wr_ends: assert property (rd |=> !arr_wr_o.en)
    else $error("write beat after read");
  a_rdap_pre: assert property (
    cut && !cwr |=> pre_start_o == $past(oh))
    else $error("precharge not started at cut");
  a_wrap_pre: assert property (
    cut && cwr |-> ##WR_DLY pre_start_o == $past(oh, WR_DLY))
    else $error("precharge after recovery wrong");
endmodule

bind sbbi_burst_ctrl sbbi_chk #(.BL(BL), .WR_CYC(WR_CYC)) u_chk (
  .sys_clk_i, .rst_i, .cmd_i, .dqm_i, .dq_i, .dq_oe_o, .arr_rd_en_o,
  .arr_rd_bank_o, .arr_wr_o, .pre_start_o);

`default_nettype wire

//--- sbbi_ctl_model.sv
`default_nettype none

// ------------------------------------
// far-end controller model
// ------------------------------------
module sbbi_ctl_model (
  input  wire logic           sys_clk_i,
  output sbbi_pkg::sbbi_cmd_t cmd_o,
  output logic [1:0]          dqm_o,
  output logic [15:0]         dq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_o = '1;
    dqm_o = 2'h3;
    dq_o  = 16'h0;
  end
  // codes: 0 idle, 1 read, 2 write, 3 precharge, 4 terminate, 5 active
  // no refresh or mode load, terminate only to the bursting bank
  task automatic put(input int k, input logic [1:0] b, input logic [7:0] c,
                     input logic ap, input logic [1:0] m,
                     input logic [15:0] d);
    @(posedge sys_clk_i);
    cmd_o <= '{k == 0, k != 3 && k != 5, k != 1 && k != 2,
               k < 2 || k == 5, b, c, ap};
    dqm_o <= m;
    dq_o  <= d;
  endtask
endmodule

`default_nettype wire

//--- sdram_bank_burst_interrupt_bench.sv
`default_nettype none

// ------------------------------------
// bench for the burst interrupt block
// ------------------------------------
module sdram_bank_burst_interrupt_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                sys_clk_i = 1'b0;
  logic                rst_i = 1'b1;
  sbbi_pkg::sbbi_cmd_t cmd_i;
  logic [1:0]          dqm_i;
  logic [15:0]         dq_i;
  logic [15:0]         dq_o;
  logic                dq_oe_o;
  logic [1:0]          arr_rd_bank_o;
  logic [7:0]          arr_rd_col_o;
  logic [15:0]         arr_rd_data_i;
  sbbi_pkg::sbbi_wr_t  arr_wr_o;
  logic [3:0]          pre_start_o;
  logic [3:0]          bank_busy_o;
  logic                burst_active_o;
  int                  err_count = 0;
  int                  checks = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  // array answers with its own address so each beat shows its origin
  assign arr_rd_data_i = {6'h28, arr_rd_bank_o, arr_rd_col_o};
  sbbi_ctl_model u_ctl (.sys_clk_i, .cmd_o(cmd_i), .dqm_o(dqm_i),
    .dq_o(dq_i));
  sbbi_burst_ctrl i_dut (.sys_clk_i, .rst_i, .cmd_i, .dqm_i, .dq_i, .dq_o,
    .dq_oe_o, .arr_rd_en_o(), .arr_rd_bank_o, .arr_rd_col_o,
    .arr_rd_data_i, .arr_wr_o, .pre_start_o, .bank_busy_o,
    .burst_active_o);

  task automatic cmp_v(input string n, input logic [16:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_s(input string n, input sbbi_pkg::sbbi_wr_t e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic step(input int k, b, c, ap, m, d);
    u_ctl.put(k, 2'(b), 8'(c), 1'(ap), 2'(m), 16'(d));
    #1;
  endtask
  task automatic rdchk(input bit on, input logic [15:0] w);
    cmp_v("dq", on ? {1'b1, w} : 17'h0, {dq_oe_o, on ? dq_o : 16'h0});
  endtask
  task automatic stbchk(input bit on, input sbbi_pkg::sbbi_wr_t e);
    if (on) cmp_s("wr", e, arr_wr_o);
    else cmp_v("wr_en", 17'h0, {16'h0, arr_wr_o.en});
  endtask

  task automatic s_rd_rd;
    logic [15:0] w;
    for (int j = 0; j < 10; j++) begin
      step(j % 2 == 0 && j < 3, j / 2, j < 1 ? 8'h12 : 8'h22, 0, 0, j);
      w = j < 5 ? {8'hA0, 6'h04, 2'(j - 1)} : {8'hA1, 6'h08, 2'(j - 3)};
      rdchk(j > 2 && j < 9, w);
      cmp_v("active", 17'(j > 0 && j < 6), 17'(burst_active_o));
    end
  endtask
  task automatic s_rd_wr;
    sbbi_pkg::sbbi_wr_t e;
    for (int j = 0; j < 10; j++) begin
      step(j == 0 ? 1 : 2 * (j == 4), j == 4, j ? 8'h50 : 8'h10, 0,
           3 * (j == 3), 16'hB000 + j);
      e = {1'b1, 2'h1, 8'(8'h4B + j), 16'(16'hAFFF + j), 2'h0};
      rdchk(j == 3, 16'hA010);
      stbchk(j > 4 && j < 9, e);
    end
  endtask
  task automatic s_wr_x(input bit w2);
    sbbi_pkg::sbbi_wr_t e;
    for (int j = 0; j < 9; j++) begin
      step(j == 0 ? 2 : (j == 2) * (w2 ? 2 : 1), j == 2, 8'h30, 0, 0,
           16'h1110 + j);
      e = {1'b1, 2'(j > 2), 8'(8'h2D + 2 * (j < 3) + j),
           16'(16'h110F + j), 2'h0};
      stbchk(j > 0 && j < (w2 ? 7 : 3), e);
      if (!w2) rdchk(j > 4, {8'hA1, 6'h0C, 2'(j - 1)});
    end
  endtask
  task automatic s_ap(input int k1, k2);
    int n;
    logic [16:0] p;
    n = 3 + (k1 == 2) * sbbi_pkg::WR_CYCLES;
    for (int j = 0; j < 9; j++) begin
      step(j == 0 ? k1 : (j == 2) * k2, 2 + (j > 0), 8'h40, j == 0,
           3 * (j < 2 && k2 == 2), 16'h7000 + j);
      p = 17'(4 * (j == n));
      cmp_v("pre", p, 17'(pre_start_o));
    end
    // no fresh burst while a bank still precharges
    for (int j = 0; j < 20 && bank_busy_o !== 4'h0; j++)
      step(0, 0, 0, 0, 0, j);
    cmp_v("busy", 17'h0, 17'(bank_busy_o));
  endtask
  task automatic s_stop;
    int k [9] = '{1, 5, 4, 0, 0, 2, 3, 0, 0};
    for (int j = 0; j < 9; j++) begin
      // active to another bank, then terminate and precharge cut bursts
      step(k[j], j == 1 || j > 4, j == 5 ? 8'h70 : 8'h60, 0, 0,
           16'h5A00 + j);
      rdchk(j == 3 || j == 4, {8'hA0, 6'h18, 2'(j - 3)});
      stbchk(j == 6, {1'b1, 2'h1, 8'h70, 16'h5A05, 2'h0});
      cmp_v("pre", 17'(2 * (j == 7)), 17'(pre_start_o));
    end
  endtask

  task automatic test_done;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    s_rd_rd();
    s_rd_wr();
    s_wr_x(1'b0);
    s_wr_x(1'b1);
    s_stop();
    for (int a = 1; a < 3; a++)
      for (int b = 1; b < 3; b++)
        s_ap(a, b);
    test_done();
  end
  // whole run is near 90 cycles, so this leaves a wide margin
  initial begin
    #5us;
    err_count++;
    test_done();
  end
endmodule

`default_nettype wire
